// >>> logic/safing_consts.svh
// Constants for the safing sample counter and dwell block.
// Assumes a 100 MHz clock and a single asynchronous active-low reset.
// Summary of operation
// - Sixteen 2-bit sample counters, one per sequence ID.
// - A counter increments when its sample exceeds its threshold.
// - Counters saturate at their maximum value.
// - Counters clear on safing reset and when a sample does not exceed.
// - Any counter at 11 drives arm high and safe hold low.
// - Safing mode holds arming during saturation plus dwell time.
// - Threshold bit 7 picks 255 ms or 2.0 s dwell.
// - Mixed dwell selections apply the longer dwell time.
// - Diagnostic mode applies no dwell extension.
// - Compare only when frame received, data valid, no sequence error.
// - Eight thresholds, each shared by two consecutive sequence numbers.
// - Unsigned compare of 9-bit magnitude against zero-extended threshold.
`ifndef SAFING_CONSTS_SVH
`define SAFING_CONSTS_SVH

`define SAF_NUM_IDS 16
`define SAF_NUM_TH 8
`define SAF_CNT_MAX 2'h3
`define SAF_CNT_ZERO 2'h0
`define SAF_DWELL_BIT 7
`define SAF_CLK_NS 10
`define SAF_DWELL_SHORT_MS 255
`define SAF_DWELL_LONG_MS 2000
`define SAF_NS_PER_MS 1000000
`define SAF_SHORT_CYC ((`SAF_DWELL_SHORT_MS * `SAF_NS_PER_MS) / `SAF_CLK_NS)
`define SAF_LONG_CYC ((`SAF_DWELL_LONG_MS * `SAF_NS_PER_MS) / `SAF_CLK_NS)

`endif

// >>> logic/safing_pkg.sv
// Types shared by the safing block.
// Assumes the constants header is compiled alongside.
`default_nettype none
package safing_pkg;
  typedef logic [1:0] sample_cnt_t;
  typedef logic [8:0] magnitude_t;
  typedef logic [7:0] threshold_t;
  typedef logic [3:0] seq_id_t;
  typedef enum logic {mode_safing_t_dummy_unused, mode_diag} op_mode_unused_t;
endpackage
`default_nettype wire

// >>> logic/sample_counter.sv
// One saturating 2-bit sample counter.
// Assumes eval is a one-cycle pulse already gated by comparison enable.
`include "safing_consts.svh"
`default_nettype none
module sample_counter
  import safing_pkg::*;
(
  input wire logic clk, // Device clock
  input wire logic nrst, // Async reset, active low
  input wire logic sm_reset, // Safing state machine reset
  input wire logic eval, // Sample for this ID evaluated
  input wire logic exceeds, // Sample strictly above threshold
  output safing_pkg::sample_cnt_t count // Counter value
);
  sample_cnt_t cnt_r;
  sample_cnt_t cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (sm_reset) begin
      cnt_nxt = `SAF_CNT_ZERO;
    end else if (eval) begin
      if (!exceeds) begin
        cnt_nxt = `SAF_CNT_ZERO;
      end else if (cnt_r != `SAF_CNT_MAX) begin
        cnt_nxt = cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= `SAF_CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;

  a_cnt_saturate: assert property (@(posedge clk) disable iff (!nrst)
    (cnt_r == `SAF_CNT_MAX && eval && exceeds && !sm_reset)
    |=> cnt_r == `SAF_CNT_MAX)
    else $error("counter left saturation on exceeding sample");
  a_cnt_clear: assert property (@(posedge clk) disable iff (!nrst)
    (sm_reset || (eval && !exceeds)) |=> cnt_r == `SAF_CNT_ZERO)
    else $error("counter not cleared");
  a_cnt_step: assert property (@(posedge clk) disable iff (!nrst)
    (eval && exceeds && !sm_reset && cnt_r != `SAF_CNT_MAX)
    |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("counter did not increment");
endmodule
`default_nettype wire

// >>> logic/safing_dwell.sv
// Safing evaluator: per-ID sample counters, arming outputs, dwell timer.
// Assumes sample inputs are synchronous strobes from upstream logic
// and thresholds come from the threshold store on the same clock.
`include "safing_consts.svh"
`default_nettype none
module safing_dwell
  import safing_pkg::*;
#(
  parameter int unsigned SHORT_CYC = `SAF_SHORT_CYC,
  parameter int unsigned LONG_CYC = `SAF_LONG_CYC
) (
  input wire logic clk, // Device clock, 100 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic sm_reset, // Safing state machine reset
  input wire logic safing_mode, // High in safing mode
  input wire logic diag_mode, // High in diagnostic mode
  input wire logic sample_strobe, // One-cycle sample arrival
  input wire logic frame_rcvd, // Message frame received
  input wire logic data_valid, // Sensor data valid
  input wire logic seq_error, // Sequence error present
  input wire safing_pkg::seq_id_t sample_id, // Sequence ID of sample
  input wire safing_pkg::magnitude_t sample_mag, // 9-bit magnitude
  input wire logic [63:0] thresholds, // Eight 8-bit thresholds, 0 low
  output logic arm, // Arming output, active high
  output logic safe_hold_output_n, // Safe_hold_output_n output, active low
  output logic dwell_active // Dwell extension running
);
  import safing_pkg::*;

  localparam int unsigned CW = $clog2(LONG_CYC + 1);

  logic cmp_en;
  threshold_t th_sel;
  logic exceeds;
  sample_cnt_t counts [`SAF_NUM_IDS];
  logic [`SAF_NUM_IDS-1:0] sat;
  logic [`SAF_NUM_IDS-1:0] long_sel;
  logic any_sat;
  logic want_long;
  logic [CW-1:0] dwell_r;
  logic [CW-1:0] dwell_nxt;
  logic long_r;
  logic long_nxt;
  logic arm_r;
  logic arm_nxt;

  // Frame, validity and sequence error gate every evaluation
  assign cmp_en = sample_strobe && frame_rcvd && data_valid
    && !seq_error;
  // IDs 2n and 2n+1 share threshold n
  assign th_sel = thresholds[sample_id[3:1]*8 +: 8];
  // Equal is not exceeding
  assign exceeds = sample_mag > {1'b0, th_sel};

  genvar g;
  generate
    for (g = 0; g < `SAF_NUM_IDS; g++) begin : g_id
      sample_counter u_cnt (
        .clk(clk),
        .nrst(nrst),
        .sm_reset(sm_reset),
        .eval(cmp_en && sample_id == 4'(g)),
        .exceeds(exceeds),
        .count(counts[g])
      );
      assign sat[g] = counts[g] == `SAF_CNT_MAX;
      assign long_sel[g] = sat[g]
        && thresholds[(g/2)*8 + `SAF_DWELL_BIT];
    end
  endgenerate

  assign any_sat = |sat;
  assign want_long = |long_sel;

  always_comb begin
    dwell_nxt = dwell_r;
    long_nxt = long_r;
    if (sm_reset || !safing_mode || diag_mode) begin
      dwell_nxt = '0;
      long_nxt = 1'b0;
    end else if (any_sat) begin
      dwell_nxt = '0;
      // Latched choice: longer one wins while any saturation lasts
      long_nxt = long_r || want_long;
    end else if (arm_r && dwell_r == '0) begin
      dwell_nxt = long_r ? CW'(LONG_CYC) : CW'(SHORT_CYC);
    end else if (dwell_r != '0) begin
      dwell_nxt = dwell_r - CW'(1);
      if (dwell_r == CW'(1)) begin
        long_nxt = 1'b0;
      end
    end
  end

  // Arming follows saturation; dwell only extends it in safing mode
  always_comb begin
    arm_nxt = 1'b0;
    if (sm_reset) begin
      arm_nxt = 1'b0;
    end else if (any_sat) begin
      arm_nxt = 1'b1;
    end else if (safing_mode && !diag_mode) begin
      arm_nxt = (arm_r && dwell_r == '0) || dwell_r > CW'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dwell_r <= '0;
      long_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      dwell_r <= dwell_nxt;
      long_r <= long_nxt;
      arm_r <= arm_nxt;
    end
  end

  assign arm = arm_r;
  assign safe_hold_output_n = !arm_r;
  assign dwell_active = dwell_r != '0;

  // Only a real arming episode ends here; a reset-cleared counter does not
  sequence s_sat_end;
    $fell(any_sat) && arm_r && safing_mode && !diag_mode && !sm_reset;
  endsequence

  // Dwell counting down with nothing to disturb it
  sequence s_dwell_run;
    dwell_r > CW'(1) && !any_sat && !sm_reset && safing_mode && !diag_mode;
  endsequence

  // Last tick of the dwell in an undisturbed safing episode
  sequence s_dwell_last;
    dwell_r == CW'(1) && !any_sat && !sm_reset && safing_mode && !diag_mode;
  endsequence

  a_arm_follow: assert property (@(posedge clk) disable iff (!nrst)
    (any_sat && !sm_reset) |=> arm && !safe_hold_output_n)
    else $error("arm not asserted on saturation");
  a_dwell_start: assert property (@(posedge clk) disable iff (!nrst)
    s_sat_end |=> arm [*2])
    else $error("arming dropped at start of dwell");
  a_long_load: assert property (@(posedge clk) disable iff (!nrst)
    (s_sat_end ##0 long_r) |=> dwell_r == CW'(LONG_CYC))
    else $error("long dwell not loaded");
  a_short_load: assert property (@(posedge clk) disable iff (!nrst)
    (s_sat_end ##0 !long_r) |=> dwell_r == CW'(SHORT_CYC))
    else $error("short dwell not loaded");
  a_dwell_count: assert property (@(posedge clk) disable iff (!nrst)
    s_dwell_run |=> dwell_r == $past(dwell_r) - CW'(1))
    else $error("dwell counter did not step down");
  a_dwell_hold: assert property (@(posedge clk) disable iff (!nrst)
    s_dwell_run |=> arm && !safe_hold_output_n)
    else $error("arming dropped during dwell");
  a_mode_exit: assert property (@(posedge clk) disable iff (!nrst)
    (!safing_mode || diag_mode) |=> dwell_r == '0)
    else $error("dwell running outside safing mode");
  a_reset_clear: assert property (@(posedge clk) disable iff (!nrst)
    sm_reset |=> !arm && dwell_r == '0 && !long_r)
    else $error("safing reset left arming state");
  // Long choice must stick for the whole episode, not the last sample
  a_long_latch: assert property (@(posedge clk) disable iff (!nrst)
    (any_sat && want_long && safing_mode && !diag_mode && !sm_reset)
    |=> long_r)
    else $error("long dwell choice not latched");
  a_long_clear: assert property (@(posedge clk) disable iff (!nrst)
    s_dwell_last |=> !long_r)
    else $error("long dwell choice outlived its dwell");
  a_arm_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (!arm_r && !any_sat && dwell_r == '0) |=> !arm)
    else $error("arm rose without saturation");
  a_cancel_arm: assert property (@(posedge clk) disable iff (!nrst)
    (any_sat && dwell_r != '0 && !sm_reset) |=> arm)
    else $error("arming lost on resaturation");
  a_diag_nodwell: assert property (@(posedge clk) disable iff (!nrst)
    (diag_mode && !any_sat) |=> !arm)
    else $error("dwell applied in diagnostic mode");
  a_resat_cancel: assert property (@(posedge clk) disable iff (!nrst)
    (any_sat && dwell_r != '0) |=> dwell_r == '0)
    else $error("dwell not cancelled on resaturation");
  a_gate_compare: assert property (@(posedge clk) disable iff (!nrst)
    (!cmp_en && !sm_reset) |=> $stable(sat))
    else $error("counter moved without enabled comparison");
  a_arm_drop: assert property (@(posedge clk) disable iff (!nrst)
    (dwell_r == CW'(1) && !any_sat && !sm_reset && safing_mode)
    |=> !arm)
    else $error("arm held past dwell end");
endmodule
`default_nettype wire

// >>> bench/arm_switch_model.sv
// Arming switch pair that the safing outputs drive.
// Assumes both lines are sampled on the device clock.
`default_nettype none
module arm_switch_model (
  input wire logic clk, // Device clock
  input wire logic arm, // High-side arming line
  input wire logic safe_hold_output_n, // Low-side line, active low
  output logic loop_en, // Loop enabled by both switches
  output logic clash // Lines once disagreed, sticky
);
  timeunit 1ns;
  timeprecision 1ns;
  // Loop closes only when both switches agree, as on the real pair
  assign loop_en = arm & ~safe_hold_output_n;
  initial clash = 1'b0;
  always @(posedge clk) begin
    if (arm !== ~safe_hold_output_n) begin
      clash <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> bench/safing_dwell_tb_top.sv
// Bench for the safing evaluator: random thresholds and samples.
// Assumes the dwell counts are shortened through the parameters.
`default_nettype none
module safing_dwell_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import safing_pkg::*;
  localparam int SC = 20;
  localparam int LC = 50;
  logic clk = 0, nrst = 0, sm_reset = 0, safing_mode = 1, diag_mode = 0;
  logic sample_strobe = 0, frame_rcvd = 1, data_valid = 1, seq_error = 0;
  seq_id_t sample_id = '0;
  magnitude_t sample_mag = '0;
  logic [63:0] thresholds = '0;
  logic arm, safe_hold_output_n, dwell_active, loop_en, clash;
  logic [2:0] bad [3] = '{3'h2, 3'h4, 3'h7};
  int n_errors = 0, check_count = 0, cyc = 0;
  always #5 clk = ~clk;
  safing_dwell #(.SHORT_CYC(SC), .LONG_CYC(LC)) i_dut (.clk(clk),
    .nrst(nrst), .sm_reset(sm_reset), .safing_mode(safing_mode),
    .diag_mode(diag_mode), .sample_strobe(sample_strobe),
    .frame_rcvd(frame_rcvd), .data_valid(data_valid),
    .seq_error(seq_error), .sample_id(sample_id),
    .sample_mag(sample_mag), .thresholds(thresholds), .arm(arm),
    .safe_hold_output_n(safe_hold_output_n), .dwell_active(dwell_active));
  arm_switch_model i_sw (.clk(clk), .arm(arm),
    .safe_hold_output_n(safe_hold_output_n), .loop_en(loop_en),
    .clash(clash));
  task automatic chk(input logic ok, input logic [31:0] got,
                     input logic [31:0] exp);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] th(input int id);
    return thresholds[8*(id/2) +: 8];
  endfunction
  function automatic int above(input int id);
    return th(id) + 1 + $urandom % (511 - th(id));
  endfunction
  task automatic smp(input int id, input int m, input logic [2:0] g = 3'h6);
    sample_strobe <= 1'b1;
    sample_id <= id[3:0];
    sample_mag <= m[8:0];
    {frame_rcvd, data_valid, seq_error} <= g;
    @(posedge clk);
  endtask
  task automatic gap(input int n);
    sample_strobe <= 1'b0;
    {frame_rcvd, data_valid, seq_error} <= 3'h6;
    repeat (n) @(posedge clk);
  endtask
  task automatic sat(input int id, input int k);
    repeat (k) smp(id, above(id));
  endtask
  // Counts cycles the loop stays enabled
  task automatic hold(input int lo, input int hi);
    int n;
    n = 0;
    while (loop_en === 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(n >= lo && n <= hi, n, hi);
  endtask
  task automatic tally_and_finish();
    chk(clash === 1'b0, clash, 0);
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    int id, d;
    void'($urandom(71275));
    thresholds <= {$urandom, $urandom};
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    chk(arm === 1'b0 && safe_hold_output_n === 1'b1, arm, 0);
    for (int k = 0; k < 4; k++) begin
      id = $urandom % 16;
      thresholds[8*(id/2)+7] <= k[0];
      diag_mode <= k[1];
      gap(1);
      sat(id, 2);
      smp(id, th(id));
      sat(id, 2);
      smp(id, above(id), bad[k%3]);
      gap(2);
      chk(arm === 1'b0, arm, 0);
      sat(id, 6);
      gap(2);
      chk(loop_en === 1'b1, arm, 1);
      smp(id, $urandom % (th(id) + 1));
      gap(1);
      d = k[1] ? 0 : (th(id) >= 8'h80 ? LC : SC);
      hold(d == 0 ? 0 : d - 2, d + 2);
      $display("test %0d done", k);
    end
    diag_mode <= 1'b0;
    thresholds[7] <= 1'b0;
    thresholds[15] <= 1'b1;
    gap(1);
    sat(1, 3);
    sat(2, 3);
    smp(1, 0);
    smp(2, 0);
    gap(1);
    hold(LC - 2, LC + 2);
    sat(0, 3);
    smp(0, 0);
    gap(SC / 2);
    chk(dwell_active === 1'b1, dwell_active, 1);
    sat(0, 3);
    gap(2);
    chk(dwell_active === 1'b0 && arm === 1'b1, dwell_active, 0);
    smp(0, 0);
    gap(1);
    hold(SC - 2, SC + 2);
    sat(5, 3);
    sm_reset <= 1'b1;
    gap(1);
    sm_reset <= 1'b0;
    sat(5, 2);
    gap(2);
    chk(arm === 1'b0, arm, 0);
    $display("test mixed, restart and clear done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
